// ### hdl/fifo_col_pkg.sv
package fifo_col_pkg;

    localparam int                ADDR_W         = 8;

    // Register numbers are word indices; the byte address is four times one
    localparam logic [7:0]        IDX_FILL_LO    = 8'h1E;
    localparam logic [7:0]        IDX_FILL_HI    = 8'h1F;
    localparam logic [7:0]        IDX_COLL       = 8'h20;
    localparam logic [ADDR_W-1:0] ADR_FILL_LO    = {IDX_FILL_LO[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADR_FILL_HI    = {IDX_FILL_HI[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADR_COLL       = {IDX_COLL[5:0], 2'b00};
    localparam logic [ADDR_W-1:0] ADR_IRQ_STAT   = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_IRQ_MASK   = 8'h04;

    localparam logic [1:0]        RESP_OKAY      = 2'h0;
    localparam logic [1:0]        RESP_DECERR    = 2'h3;

    localparam logic [9:0]        FIFO_DEPTH     = 10'h200;
    localparam logic [9:0]        FILL_RST       = 10'h000;
    // Most complete bytes before a collision whose position is still recorded
    localparam logic [3:0]        ACOL_MAX_BYTES = 4'h7;

    // Sticky FIFO flag positions
    localparam int                FL_OVR         = 0;
    localparam int                FL_UNF         = 1;
    localparam int                FL_W           = 2;

    // Interrupt status and mask bit positions
    localparam int                EV_OVR         = 0;
    localparam int                EV_UNF         = 1;
    localparam int                EV_COL         = 2;
    localparam int                EV_HFE         = 3;
    localparam int                EV_W           = 4;
    localparam logic [EV_W-1:0]   MASK_RST       = 4'h0;

    typedef struct packed {
        logic [1:0] cnt_hi;
        logic       unf;
        logic       ovr;
        logic [2:0] last_byte_bit_count;
        logic       missing_parity_flag;
    } fill_hi_reg_s;

    typedef struct packed {
        logic [3:0] bytes;
        logic [2:0] bits;
        logic       parity_collision_flag;
    } coll_reg_s;

    // Receive decoder strobes, all one-cycle pulses except the modes
    typedef struct packed {
        logic start;          // Frame start
        logic bit_stb;        // Data bit valid
        logic rx_bit;         // Data bit value, LSB first
        logic par_stb;        // Parity bit received
        logic frame_end;      // Frame end
        logic par_en;         // Frame carries parity bits
        logic col;            // Collision seen at current bit
        logic col_par;        // That collision lies on the parity bit
        logic anticol;        // Frame is an anticollision command
        logic frame_err;      // Framing error
        logic frame_err_hard; // Framing error corrupts the data
    } rx_in_s;

endpackage : fifo_col_pkg

// ### hdl/sticky_bits.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_bits #(
    parameter int W = 1
) (
    input  wire logic         aclk,    // Clock
    input  wire logic         aresetn, // Sync reset, active low
    input  wire logic [W-1:0] set,     // Set pulses
    input  wire logic [W-1:0] clr,     // Clear pulses
    output logic      [W-1:0] bits_q   // Sticky flags
);
    typedef struct packed {
        logic [W-1:0] bits;
    } st_s;

    st_s st_q;
    st_s st_d;

    // Set beats clear so an event in the clearing cycle survives
    always_comb begin
        st_d      = st_q;
        st_d.bits = (st_q.bits & ~clr) | set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign bits_q = st_q.bits;
endmodule : sticky_bits
`default_nettype wire

// ### hdl/fill_counter.sv
`timescale 1ns/1ps
`default_nettype none
module fill_counter import fifo_col_pkg::*; (
    input  wire logic       aclk,    // Clock
    input  wire logic       aresetn, // Sync reset, active low
    input  wire logic       clr,     // FIFO clear
    input  wire logic [1:0] push_n,  // Bytes written this cycle
    input  wire logic       pop,     // Byte read this cycle
    output logic      [9:0] count_q, // Fill count
    output logic            ovr_q,   // Overflow pulse
    output logic            unf_q    // Underflow pulse
);
    typedef struct packed {
        logic [9:0] count;
        logic       ovr;
        logic       unf;
    } st_s;

    st_s st_q;
    st_s st_d;

    always_comb begin
        logic [10:0] nxt;
        logic        take;
        nxt      = '0;
        take     = pop && (st_q.count != 10'h000);
        st_d     = st_q;
        st_d.unf = pop && (st_q.count == 10'h000);
        st_d.ovr = 1'b0;
        nxt = {1'b0, st_q.count} - {10'h000, take} + {9'h000, push_n};
        if (nxt > {1'b0, FIFO_DEPTH}) begin
            st_d.ovr = 1'b1;
            nxt      = {1'b0, FIFO_DEPTH};
        end
        st_d.count = nxt[9:0];
        if (clr) begin
            st_d.count = FILL_RST;
            st_d.ovr   = 1'b0;
            st_d.unf   = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count_q = st_q.count;
    assign ovr_q   = st_q.ovr;
    assign unf_q   = st_q.unf;
endmodule : fill_counter
`default_nettype wire

// ### hdl/fifo_collision_status.sv
`timescale 1ns/1ps
`default_nettype none
module fifo_collision_status import fifo_col_pkg::*; (
    input  wire logic              aclk,        // Clock, 125 MHz
    input  wire logic              aresetn,     // Sync reset, active low
    input  wire logic [ADDR_W-1:0] awaddr,      // Write address
    input  wire logic [2:0]        awprot,      // Write protection, unused
    input  wire logic              awvalid,     // Write address valid
    output logic                   awready,     // Write address ready
    input  wire logic [31:0]       wdata,       // Write data
    input  wire logic [3:0]        wstrb,       // Write strobes
    input  wire logic              wvalid,      // Write data valid
    output logic                   wready,      // Write data ready
    output logic      [1:0]        bresp,       // Write response
    output logic                   bvalid,      // Write response valid
    input  wire logic              bready,      // Write response ready
    input  wire logic [ADDR_W-1:0] araddr,      // Read address
    input  wire logic [2:0]        arprot,      // Read protection, unused
    input  wire logic              arvalid,     // Read address valid
    output logic                   arready,     // Read address ready
    output logic      [31:0]       rdata,       // Read data
    output logic      [1:0]        rresp,       // Read response
    output logic                   rvalid,      // Read data valid
    input  wire logic              rready,      // Read data ready
    input  wire rx_in_s            rx,          // Receive decoder strobes
    input  wire logic              host_push,   // Host loaded a byte
    input  wire logic              host_pop,    // Byte taken out of FIFO
    input  wire logic              fifo_clear,  // FIFO clear command
    output logic                   rx_push,     // Received byte to storage
    output logic      [7:0]        rx_push_data, // Received byte value
    output logic                   irq          // Interrupt, active high
);
    typedef struct packed {
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic             aw_held;
        logic [7:0]       aw_addr;
        logic             w_held;
        logic [7:0]       w_byte;
        logic             w_lane0;
        logic [EV_W-1:0]  mask;
        logic             irq;
        logic [7:0]       shreg;
        logic [2:0]       bitcnt;
        logic [3:0]       bytes;
        logic             par_pend;
        logic [2:0]       lb;
        logic             np;
        coll_reg_s        col;
        logic             col_seen;
        logic             push;
        logic [7:0]       push_data;
    } st_s;

    st_s             st_q;
    st_s             st_d;
    logic [9:0]      fill_cnt;
    logic            fc_ovr;
    logic            fc_unf;
    logic [FL_W-1:0] fifo_flags;
    logic [FL_W-1:0] flag_set;
    logic [EV_W-1:0] irq_status;
    logic [EV_W-1:0] irq_set;
    logic [EV_W-1:0] irq_clr;
    logic            rd_take;
    logic            col_take;
    logic            hfe_evt;

    assign rd_take  = arvalid && st_q.arready;
    // record only the first collision of a short anticollision frame
    assign col_take = rx.col && !rx.start && !st_q.col_seen && rx.anticol
                      && (st_q.bytes <= ACOL_MAX_BYTES);
    // soft framing errors never raise the hard error bit
    assign hfe_evt  = rx.frame_err && rx.frame_err_hard;

    assign flag_set[FL_UNF] = fc_unf;
    assign flag_set[FL_OVR] = fc_ovr;

    assign irq_set[EV_OVR] = fc_ovr;
    assign irq_set[EV_UNF] = fc_unf;
    assign irq_set[EV_COL] = col_take;
    assign irq_set[EV_HFE] = hfe_evt;
    // Reading the status word clears it; a coinciding event still lands
    assign irq_clr = {EV_W{rd_take && ({araddr[7:2], 2'b00} == ADR_IRQ_STAT)}};

    fill_counter u_fill (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (fifo_clear),
        .push_n  ({st_q.push & host_push, st_q.push ^ host_push}),
        .pop     (host_pop),
        .count_q (fill_cnt),
        .ovr_q   (fc_ovr),
        .unf_q   (fc_unf)
    );

    sticky_bits #(.W(FL_W)) u_flags (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (flag_set),
        .clr     ({FL_W{fifo_clear}}),
        .bits_q  (fifo_flags)
    );

    sticky_bits #(.W(EV_W)) u_irq (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (irq_set),
        .clr     (irq_clr),
        .bits_q  (irq_status)
    );

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] w;
        w = {a[7:2], 2'b00};
        return (w == ADR_FILL_LO) || (w == ADR_FILL_HI) || (w == ADR_COLL)
               || (w == ADR_IRQ_STAT) || (w == ADR_IRQ_MASK);
    endfunction : mapped

    function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a);
        fill_hi_reg_s hi;
        logic [31:0]  r;
        hi.cnt_hi              = fill_cnt[9:8];
        hi.unf                 = fifo_flags[FL_UNF];
        hi.ovr                 = fifo_flags[FL_OVR];
        hi.last_byte_bit_count = st_q.lb;
        hi.missing_parity_flag = st_q.np;
        r = 32'h0000_0000;
        unique case ({a[7:2], 2'b00})
            // fill count split over two registers
            ADR_FILL_LO:  r = {24'h00_0000, fill_cnt[7:0]};
            ADR_FILL_HI:  r = {24'h00_0000, hi};
            ADR_COLL:     r = {24'h00_0000, st_q.col};
            ADR_IRQ_STAT: r = {28'h000_0000, irq_status};
            ADR_IRQ_MASK: r = {28'h000_0000, st_q.mask};
            default:      r = 32'h0000_0000;
        endcase
        return r;
    endfunction : rd_word

    always_comb begin
        logic [7:0] shifted;
        shifted   = {rx.rx_bit, st_q.shreg[7:1]};
        st_d      = st_q;
        st_d.push = 1'b0;

        // Write side: address and data are taken in either order
        if (awvalid && st_q.awready) begin
            st_d.aw_held = 1'b1;
            st_d.aw_addr = awaddr;
        end
        if (wvalid && st_q.wready) begin
            st_d.w_held  = 1'b1;
            st_d.w_byte  = wdata[7:0];
            st_d.w_lane0 = wstrb[0];
        end
        if (st_q.bvalid && bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
            st_d.aw_held = 1'b0;
            st_d.w_held  = 1'b0;
            st_d.bvalid  = 1'b1;
            st_d.bresp   = mapped(st_q.aw_addr) ? RESP_OKAY : RESP_DECERR;
            // Only the mask is writable; status words ignore writes
            if (({st_q.aw_addr[7:2], 2'b00} == ADR_IRQ_MASK)
                && st_q.w_lane0) begin
                st_d.mask = st_q.w_byte[EV_W-1:0];
            end
        end
        st_d.awready = !st_d.aw_held && !st_d.bvalid;
        st_d.wready  = !st_d.w_held && !st_d.bvalid;

        // Read side: one outstanding read, data one cycle after the address
        if (st_q.rvalid && rready) begin
            st_d.rvalid = 1'b0;
        end
        if (rd_take) begin
            st_d.rvalid = 1'b1;
            st_d.rdata  = rd_word(araddr);
            st_d.rresp  = mapped(araddr) ? RESP_OKAY : RESP_DECERR;
        end
        st_d.arready = !st_d.rvalid;

        // Receive assembly, LSB first
        if (rx.start) begin
            st_d.bitcnt   = 3'h0;
            st_d.bytes    = 4'h0;
            st_d.par_pend = 1'b0;
            st_d.lb       = 3'h0;
            st_d.np       = 1'b0;
            // no collision yet, parity collision flag cleared
            st_d.col      = '0;
            st_d.col_seen = 1'b0;
        end else begin
            if (rx.bit_stb) begin
                st_d.shreg  = shifted;
                st_d.bitcnt = st_q.bitcnt + 3'h1;
                if (st_q.bitcnt == 3'h7) begin
                    st_d.push      = 1'b1;
                    st_d.push_data = shifted;
                    st_d.par_pend  = rx.par_en;
                    if (st_q.bytes != 4'hF) begin
                        st_d.bytes = st_q.bytes + 4'h1;
                    end
                end
            end
            if (rx.par_stb) begin
                st_d.par_pend = 1'b0;
            end
            // Later collisions in the same frame do not move the record
            if (rx.col) begin
                st_d.col_seen = 1'b1;
            end
            if (col_take) begin
                st_d.col.bytes                 = st_q.bytes;
                st_d.col.bits                  = st_q.bitcnt;
                st_d.col.parity_collision_flag = rx.col_par;
            end
            if (rx.frame_end) begin
                st_d.bitcnt = 3'h0;
                if (st_q.bitcnt != 3'h0) begin
                    st_d.push      = 1'b1;
                    st_d.push_data = st_q.shreg >> (3'h0 - st_q.bitcnt);
                    st_d.lb        = st_q.bitcnt;
                    st_d.np        = 1'b0;
                end else begin
                    st_d.lb = 3'h0;
                    // complete byte, parity bit never came
                    st_d.np = st_q.par_pend;
                end
            end
        end

        st_d.irq = |(irq_status & st_q.mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q      <= '0;
            st_q.mask <= MASK_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign awready      = st_q.awready;
    assign wready       = st_q.wready;
    assign bvalid       = st_q.bvalid;
    assign bresp        = st_q.bresp;
    assign arready      = st_q.arready;
    assign rvalid       = st_q.rvalid;
    assign rresp        = st_q.rresp;
    assign rdata        = st_q.rdata;
    assign rx_push      = st_q.push;
    assign rx_push_data = st_q.push_data;
    assign irq          = st_q.irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_fill_read: assert property (
        rd_take && araddr == ADR_FILL_HI
        |=> rdata[7:6] == $past(fill_cnt[9:8]) && rvalid)
        else $error("fill count high bits misreported");
    chk_fill_range: assert property (
        fill_cnt <= FIFO_DEPTH)
        else $error("fill count above depth");
    chk_unf_flag: assert property (
        host_pop && fill_cnt == 10'h000 && !fifo_clear |-> ##2 fifo_flags[FL_UNF])
        else $error("underflow not flagged");
    chk_ovr_flag: assert property (
        fill_cnt == FIFO_DEPTH && host_push && !host_pop && !fifo_clear
        |-> ##2 fifo_flags[FL_OVR])
        else $error("overflow not flagged");
    chk_last_bits: assert property (
        rx.frame_end && !rx.start && st_q.bitcnt != 3'h0
        |=> st_q.lb == $past(st_q.bitcnt) && !st_q.np)
        else $error("last byte bit count wrong");
    chk_partial_lsb: assert property (
        rx.frame_end && !rx.start && st_q.bitcnt == 3'h3
        |=> rx_push && rx_push_data[7:3] == 5'h00)
        else $error("partial byte not right aligned");
    chk_np_flag: assert property (
        rx.frame_end && !rx.start && st_q.bitcnt == 3'h0 && st_q.par_pend
        && !rx.par_stb |=> st_q.np)
        else $error("missing parity not flagged");
    chk_col_pos: assert property (
        col_take |=> st_q.col.bytes == $past(st_q.bytes)
        && st_q.col.bits == $past(st_q.bitcnt))
        else $error("collision position wrong");
    chk_col_range: assert property (
        rx.col && !rx.start && (!rx.anticol || st_q.bytes > ACOL_MAX_BYTES)
        |=> $stable(st_q.col))
        else $error("collision recorded outside range");
    chk_col_parity: assert property (
        col_take |=> st_q.col.parity_collision_flag == $past(rx.col_par))
        else $error("parity collision flag wrong");
    chk_hfe_only: assert property (
        $rose(irq_status[EV_HFE]) |-> $past(rx.frame_err && rx.frame_err_hard))
        else $error("hard framing bit without hard error");
    chk_fill_step: assert property (
        host_push && !st_q.push && !host_pop && !fifo_clear
        && fill_cnt < FIFO_DEPTH |=> fill_cnt == $past(fill_cnt) + 10'h001)
        else $error("fill count did not step");

    cov_overflow: cover property (fifo_flags[FL_OVR]);
    cov_col_parity: cover property (col_take && rx.col_par);
    cov_partial: cover property (rx.frame_end && st_q.bitcnt != 3'h0);
    cov_irq_clear: cover property (irq && rd_take && araddr == ADR_IRQ_STAT);
endmodule : fifo_collision_status
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fifo_col_pkg::*;
;
    typedef struct {
        int         n;
        bit         p;
        bit         ac;
        int         cp;
        bit         cq;
        logic [3:0] nib;
        logic [7:0] col;
    } row_s;

    logic              aclk, aresetn, awvalid, awready, wvalid, wready;
    logic              bvalid, bready, arvalid, arready, rvalid, rready;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, d;
    logic [1:0]        bresp, rresp, r;
    logic              host_push, host_pop, fifo_clear, rx_push, irq;
    logic [7:0]        rx_push_data, exp_b;
    rx_in_s            rx, v;
    int                fails, total_checks, exp_fill, pushes;
    // Bits mark first collision; the 80-bit frame lies past the recorded range
    row_s rows [11] = '{
        '{3, 1, 0, -1, 0, 4'h6, 8'h00}, '{7, 1, 0, -1, 0, 4'hE, 8'h00},
        '{8, 1, 0, -1, 0, 4'h1, 8'h00}, '{8, 0, 0, -1, 0, 4'h0, 8'h00},
        '{13, 1, 0, -1, 0, 4'hA, 8'h00}, '{16, 1, 0, -1, 0, 4'h1, 8'h00},
        '{20, 1, 1, 13, 0, 4'h8, 8'h1A}, '{80, 1, 1, 72, 0, 4'h1, 8'h00},
        '{64, 1, 1, 56, 0, 4'h1, 8'h70}, '{16, 1, 1, 8, 1, 4'h1, 8'h11},
        '{16, 0, 0, 5, 0, 4'h0, 8'h00}};

    fifo_collision_status fifo_collision_status_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rx(rx), .host_push(host_push), .host_pop(host_pop),
        .fifo_clear(fifo_clear), .rx_push(rx_push),
        .rx_push_data(rx_push_data), .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Bytes handed to storage, to be matched against the fill count
    always @(posedge aclk) begin
        if (rx_push === 1'b1) pushes++;
    end

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    // Values are sampled at the negedge before the handshake edge
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        @(negedge aclk);
        while (arready !== 1'b1) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (rvalid !== 1'b1) @(negedge aclk);
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        bit ta, tw, fa, fw;
        fa = 0;
        fw = 0;
        awaddr <= a;
        wdata <= x;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awready === 1'b1;
            tw = wready === 1'b1;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            fa |= ta;
            fw |= tw;
        end while (!(fa && fw));
        @(negedge aclk);
        while (bvalid !== 1'b1) @(negedge aclk);
        r = bresp;
        @(posedge aclk);
    endtask : wr

    task automatic rxc(input rx_in_s x);
        @(posedge aclk);
        rx <= x;
    endtask : rxc

    task automatic frame(int n, bit p, bit ac, int cp, bit cq);
        int s;
        v = '0;
        v.par_en = p;
        v.anticol = ac;
        v.col_par = cq;
        v.start = 1'b1;
        rxc(v);
        v.start = 1'b0;
        for (int i = 0; i < n; i++) begin
            if (i == cp) begin
                v.col = 1'b1;
                rxc(v);
                v.col = 1'b0;
            end
            v.bit_stb = 1'b1;
            v.rx_bit = i[0] ^ i[2];
            rxc(v);
            v.bit_stb = 1'b0;
            // Parity dropped after the final byte only
            if (p && i % 8 == 7 && i != n - 1) begin
                v.par_stb = 1'b1;
                rxc(v);
                v.par_stb = 1'b0;
            end
        end
        v.frame_end = 1'b1;
        rxc(v);
        repeat (4) rxc('0);
        s = ((n - 1) / 8) * 8;
        exp_b = 8'h00;
        for (int j = 0; j < n - s; j++) begin
            exp_b[j] = 1'((s + j) % 2 ^ ((s + j) / 4) % 2);
        end
        exp_fill += (n + 7) / 8;
    endtask : frame

    task automatic hs(int n, bit pu, bit po, bit cl);
        repeat (n) begin
            host_push <= pu;
            host_pop <= po;
            fifo_clear <= cl;
            @(posedge aclk);
        end
        host_push <= 1'b0;
        host_pop <= 1'b0;
        fifo_clear <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask : hs

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        wrap_up();
    end

    initial begin
        {aresetn, awvalid, wvalid, arvalid, host_push, host_pop} = '0;
        {awaddr, araddr, wdata, fifo_clear, fails, total_checks} = '0;
        {rx, exp_fill, pushes} = '0;
        bready = 1'b1;
        rready = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(ADR_IRQ_MASK);
        chk(d, 32'h0);
        rd(ADR_COLL);
        chk(d, 32'h0);
        foreach (rows[k]) begin
            frame(rows[k].n, rows[k].p, rows[k].ac, rows[k].cp, rows[k].cq);
            chk(rx_push_data, exp_b);
            chk(pushes, exp_fill);
            rd(ADR_FILL_LO);
            chk(d, 32'(exp_fill));
            rd(ADR_FILL_HI);
            chk(d, {28'h0, rows[k].nib});
            rd(ADR_COLL);
            chk(d, {24'h0, rows[k].col});
        end
        chk(irq, 1'b0);
        rd(ADR_IRQ_STAT);
        chk(d, 32'(1 << EV_COL));
        wr(ADR_IRQ_MASK, 32'hF);
        frame(20, 1, 1, 13, 0);
        chk(irq, 1'b1);
        rd(ADR_IRQ_STAT);
        chk(d, 32'(1 << EV_COL));
        repeat (3) @(posedge aclk);
        chk(irq, 1'b0);
        v = '0;
        v.frame_err = 1'b1;
        rxc(v);
        repeat (3) rxc('0);
        rd(ADR_IRQ_STAT);
        chk(d, 32'h0);
        v.frame_err_hard = 1'b1;
        rxc(v);
        repeat (3) rxc('0);
        rd(ADR_IRQ_STAT);
        chk(d, 32'(1 << EV_HFE));
        hs(1, 0, 0, 1);
        hs(1, 0, 1, 0);
        rd(ADR_FILL_HI);
        chk(d[7:4], 4'h2);
        rd(ADR_IRQ_STAT);
        chk(d, 32'(1 << EV_UNF));
        hs(1, 0, 0, 1);
        hs(513, 1, 0, 0);
        rd(ADR_FILL_LO);
        chk(d, 32'h0);
        rd(ADR_FILL_HI);
        chk(d[7:4], 4'h9);
        rd(ADR_IRQ_STAT);
        chk(d, 32'(1 << EV_OVR));
        hs(1, 0, 0, 1);
        hs(2, 1, 0, 0);
        hs(1, 1, 1, 0);
        hs(1, 0, 1, 0);
        rd(ADR_FILL_LO);
        chk(d, 32'h1);
        wr(ADR_FILL_LO, 32'h55);
        chk(r, RESP_OKAY);
        rd(ADR_FILL_LO);
        chk(d, 32'h1);
        rd(8'h40);
        chk(r, RESP_DECERR);
        chk(d, 32'h0);
        wr(8'h44, 32'h1);
        chk(r, RESP_DECERR);
        rd(ADR_IRQ_MASK);
        chk(d, 32'hF);
        // Mid-run reset must return count, mask and outputs to zero
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(irq, 1'b0);
        chk(rx_push_data, 8'h00);
        rd(ADR_FILL_LO);
        chk(r, RESP_OKAY);
        chk(d, 32'h0);
        rd(ADR_IRQ_MASK);
        chk(d, 32'h0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
